// ### shared/ifpeu_pkg.sv
package ifpeu_pkg;

    // ************************************************************
    // special function register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_ENABLE_A     = 8'he6;
    localparam logic [7:0] ADDR_ENABLE_B     = 8'he7;
    localparam logic [7:0] ADDR_FLAGS_A      = 8'hf1;
    localparam logic [7:0] ADDR_PIN_SELECT   = 8'hf2;
    localparam logic [7:0] ADDR_PRIORITY_B   = 8'hf4;
    localparam logic [7:0] ADDR_PRIORITY_A   = 8'hf6;
    localparam logic [7:0] ADDR_EDGE_SELECT  = 8'hf7;

    // ************************************************************
    // writable bit masks, reserved bits stay zero
    // ************************************************************
    localparam logic [7:0] MASK_ENABLE_A     = 8'hfc;
    localparam logic [7:0] MASK_ENABLE_B     = 8'h07;
    localparam logic [7:0] MASK_FLAGS_A      = 8'hfc;
    localparam logic [7:0] MASK_PIN_SELECT   = 8'h7f;
    localparam logic [7:0] MASK_PRIORITY_B   = 8'h07;
    localparam logic [7:0] MASK_PRIORITY_A   = 8'hfc;
    localparam logic [7:0] MASK_EDGE_SELECT  = 8'h3f;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_ENABLE_A      = 8'h00;
    localparam logic [7:0] RST_ENABLE_B      = 8'h00;
    localparam logic [7:0] RST_FLAGS_A       = 8'h00;
    localparam logic [7:0] RST_PIN_SELECT    = 8'h40;
    localparam logic [7:0] RST_PRIORITY_B    = 8'h00;
    localparam logic [7:0] RST_PRIORITY_A    = 8'h00;
    localparam logic [7:0] RST_EDGE_SELECT   = 8'h15;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int FLAG_EXT_LINE2_BIT  = 2;  // flags 7..2: wdt, led, ...
    localparam int SRC_HI_LSB          = 2;  // first source bit in reg a
    localparam int NUM_EXT_LINES       = 3;
    localparam int NUM_SOURCES         = 9;
    localparam int LINE0_EDGE_LSB      = 0;
    localparam int LINE1_EDGE_LSB      = 2;
    localparam int LINE2_EDGE_LSB      = 4;
    localparam int LINE0_ROUTE_BIT     = 0;
    localparam int LINE1_ROUTE_BIT     = 1;
    localparam int LINE2_ROUTE_BIT     = 2;

    // ************************************************************
    // edge field codes, any other code means both edges
    // ************************************************************
    localparam logic [1:0] EDGE_FALLING = 2'h1;
    localparam logic [1:0] EDGE_RISING  = 2'h2;

    // source index as presented to the core
    typedef logic [3:0] ifpeu_src_t;

endpackage

// ### shared/ifpeu_ext_if.sv
`timescale 1ns/1ps
interface ifpeu_ext_if;
    logic [5:0] edge_field;     // two bits per line
    logic [2:0] pin_route;      // per line route enable
    logic [2:0] edge_pulse;     // one-cycle qualifying edge
    logic [2:0] wake_level;     // line sits at its wake level

    modport ctrl (
        output edge_field,
        output pin_route,
        input  edge_pulse,
        input  wake_level
    );
    modport lines (
        input  edge_field,
        input  pin_route,
        output edge_pulse,
        output wake_level
    );
endinterface

// ### design/ifpeu_ext_lines.sv
`timescale 1ns/1ps
module ifpeu_ext_lines
    import ifpeu_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // raw pins: bit 0 line zero, bit 1 line one, bit 2 line two
    input  wire logic [2:0] line_pin,
    // control side
    ifpeu_ext_if.lines      ext
);

    // ************************************************************
    // per line synchroniser and edge detector
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_EXT_LINES; g++) begin : g_line
            logic       meta;
            logic       sync;
            logic       prev;
            logic [1:0] field;
            logic       rise_ok;
            logic       fall_ok;

            assign field   = ext.edge_field[2*g +: 2];
            // 00 and 11 both mean double edge
            assign rise_ok = (field != EDGE_FALLING);
            assign fall_ok = (field != EDGE_RISING);

            always_ff @(posedge clk) begin
                if (!nrst) begin
                    meta <= 1'b1;
                    sync <= 1'b1;
                end else begin
                    meta <= line_pin[g];
                    sync <= meta;
                end
            end

            // prev keeps tracking while unrouted, so no false edge
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    prev <= 1'b1;
                end else begin
                    prev <= sync;
                end
            end

            always_ff @(posedge clk) begin
                if (!nrst) begin
                    ext.edge_pulse[g] <= 1'b0;
                end else begin
                    ext.edge_pulse[g] <= ext.pin_route[g] &
                        ((rise_ok & sync & ~prev) |
                         (fall_ok & ~sync & prev));
                end
            end

            // wake level: high for rising, low otherwise
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    ext.wake_level[g] <= 1'b0;
                end else if (field == EDGE_RISING) begin
                    ext.wake_level[g] <= ext.pin_route[g] & sync;
                end else begin
                    ext.wake_level[g] <= ext.pin_route[g] & ~sync;
                end
            end
        end
    endgenerate

endmodule

// ### design/ifpeu_top.sv
`timescale 1ns/1ps
module ifpeu_top
    import ifpeu_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // special function register access from the core
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // peripheral event pulses: 4 wdt/t2, 3 led, 2 cap, 1 adc, 0 iic
    input  wire logic [4:0] periph_event,
    // flags kept elsewhere: 2 uart1, 1 uart0, 0 low voltage
    input  wire logic [2:0] remote_flag,
    // core service state and idle mode
    input  wire logic       svc_low,
    input  wire logic       svc_high,
    input  wire logic       idle_mode,
    // external interrupt pins
    input  wire logic       port_d_bit0,
    input  wire logic       port_d_bit6,
    input  wire logic       port_d_bit7,
    // request to the core
    output logic            irq_req,
    output logic            irq_high,
    output ifpeu_src_t      irq_src,
    // edge events for lines zero and one, flags live in the core
    output logic            ext_edge_line0,
    output logic            ext_edge_line1,
    // idle wake request
    output logic            idle_wake
);

    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0] enable_a;
    logic [7:0] enable_b;
    logic [7:0] interrupt_flags_a;
    logic [7:0] peripheral_pin_select;
    logic [7:0] priority_level_b;
    logic [7:0] priority_level_a;
    logic [7:0] ext_irq_edge_select;

    // line fields
    logic [1:0] line2_edge_field;
    logic [1:0] line1_edge_field;
    logic [1:0] line0_edge_field;
    logic       line2_pin_route;
    logic       line1_pin_route;
    logic       line0_pin_route;

    // field slices
    assign line2_edge_field = ext_irq_edge_select[LINE2_EDGE_LSB +: 2];
    assign line1_edge_field = ext_irq_edge_select[LINE1_EDGE_LSB +: 2];
    assign line0_edge_field = ext_irq_edge_select[LINE0_EDGE_LSB +: 2];
    assign line2_pin_route  = peripheral_pin_select[LINE2_ROUTE_BIT];
    assign line1_pin_route  = peripheral_pin_select[LINE1_ROUTE_BIT];
    assign line0_pin_route  = peripheral_pin_select[LINE0_ROUTE_BIT];

    // decoded write strobes
    logic wr_en_a;
    logic wr_en_b;
    logic wr_flags;
    logic wr_pins;
    logic wr_prio_b;
    logic wr_prio_a;
    logic wr_edge;

    assign wr_en_a   = sfr_wr && (sfr_addr == ADDR_ENABLE_A);
    assign wr_en_b   = sfr_wr && (sfr_addr == ADDR_ENABLE_B);
    assign wr_flags  = sfr_wr && (sfr_addr == ADDR_FLAGS_A);
    assign wr_pins   = sfr_wr && (sfr_addr == ADDR_PIN_SELECT);
    assign wr_prio_b = sfr_wr && (sfr_addr == ADDR_PRIORITY_B);
    assign wr_prio_a = sfr_wr && (sfr_addr == ADDR_PRIORITY_A);
    assign wr_edge   = sfr_wr && (sfr_addr == ADDR_EDGE_SELECT);

    // ************************************************************
    // external line unit
    // ************************************************************
    ifpeu_ext_if ext ();

    assign ext.edge_field = {line2_edge_field, line1_edge_field,
                             line0_edge_field};
    assign ext.pin_route  = {line2_pin_route, line1_pin_route,
                             line0_pin_route};

    ifpeu_ext_lines u_lines (
        .clk      (clk),
        .nrst     (nrst),
        .line_pin ({port_d_bit7, port_d_bit6, port_d_bit0}),
        .ext      (ext.lines)
    );

    // ************************************************************
    // configuration registers
    // ************************************************************

    always_ff @(posedge clk) begin
        if (!nrst) begin
            enable_a <= RST_ENABLE_A;
            enable_b <= RST_ENABLE_B;
        end else begin
            if (wr_en_a) begin
                enable_a <= sfr_wdata & MASK_ENABLE_A;
            end
            if (wr_en_b) begin
                enable_b <= sfr_wdata & MASK_ENABLE_B;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            priority_level_a <= RST_PRIORITY_A;
            priority_level_b <= RST_PRIORITY_B;
        end else begin
            if (wr_prio_a) begin
                priority_level_a <= sfr_wdata & MASK_PRIORITY_A;
            end
            if (wr_prio_b) begin
                priority_level_b <= sfr_wdata & MASK_PRIORITY_B;
            end
        end
    end

    // pin routing; upper bits only stored for other blocks
    always_ff @(posedge clk) begin
        if (!nrst) begin
            peripheral_pin_select <= RST_PIN_SELECT;
        end else if (wr_pins) begin
            peripheral_pin_select <= sfr_wdata & MASK_PIN_SELECT;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_irq_edge_select <= RST_EDGE_SELECT;
        end else if (wr_edge) begin
            ext_irq_edge_select <= sfr_wdata & MASK_EDGE_SELECT;
        end
    end

    // ************************************************************
    // interrupt flags
    // ************************************************************
    logic [7:0] flag_set;

    assign flag_set = {periph_event, ext.edge_pulse[2], 2'b00};

    // flags, a hardware set beats a same-cycle software clear
    // one edge sets the line-two flag once
    always_ff @(posedge clk) begin
        if (!nrst) begin
            interrupt_flags_a <= RST_FLAGS_A;
        end else if (wr_flags) begin
            interrupt_flags_a <= (sfr_wdata | flag_set) & MASK_FLAGS_A;
        end else begin
            interrupt_flags_a <= (interrupt_flags_a | flag_set)
                                 & MASK_FLAGS_A;
        end
    end

    // lines zero and one: edges go on to the core's own flags
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_edge_line0 <= 1'b0;
            ext_edge_line1 <= 1'b0;
        end else begin
            ext_edge_line0 <= ext.edge_pulse[0];
            ext_edge_line1 <= ext.edge_pulse[1];
        end
    end

    // ************************************************************
    // request selection
    // ************************************************************
    logic [NUM_SOURCES-1:0] pending;
    logic [NUM_SOURCES-1:0] prio_bits;
    logic                   next_req;
    logic                   next_high;
    ifpeu_src_t             next_src;

    // index 0 low voltage, 1 uart0, 2 uart1, 3 line two ... 8 wdt
    assign pending   = {interrupt_flags_a[7:SRC_HI_LSB]
                        & enable_a[7:SRC_HI_LSB],
                        remote_flag & enable_b[2:0]};
    assign prio_bits = {priority_level_a[7:SRC_HI_LSB],
                        priority_level_b[2:0]};

    // high level first, lowest index wins within a level
    always_comb begin
        logic hi_found;
        logic lo_found;
        ifpeu_src_t hi_src;
        ifpeu_src_t lo_src;
        hi_found = 1'b0;
        lo_found = 1'b0;
        hi_src   = '0;
        lo_src   = '0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (pending[i] && prio_bits[i]) begin
                hi_found = 1'b1;
                hi_src   = ifpeu_src_t'(i);
            end
            if (pending[i] && !prio_bits[i]) begin
                lo_found = 1'b1;
                lo_src   = ifpeu_src_t'(i);
            end
        end
        // a high request may preempt low service, never high service
        if (hi_found && !svc_high) begin
            next_req  = 1'b1;
            next_high = 1'b1;
            next_src  = hi_src;
        end else if (lo_found && !svc_high && !svc_low) begin
            next_req  = 1'b1;
            next_high = 1'b0;
            next_src  = lo_src;
        end else begin
            next_req  = 1'b0;
            next_high = 1'b0;
            next_src  = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_req  <= 1'b0;
            irq_high <= 1'b0;
            irq_src  <= '0;
        end else begin
            irq_req  <= next_req;
            irq_high <= next_high;
            irq_src  <= next_src;
        end
    end

    // ************************************************************
    // idle wake
    // ************************************************************

    // any routed line at its wake level while idle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            idle_wake <= 1'b0;
        end else begin
            idle_wake <= idle_mode && (|ext.wake_level);
        end
    end

    // ************************************************************
    // read back
    // ************************************************************
    logic [7:0] next_rdata;

    // unmapped addresses read as zero, reserved bits are held zero
    always_comb begin
        case (sfr_addr)
            ADDR_ENABLE_A:    next_rdata = enable_a;
            ADDR_ENABLE_B:    next_rdata = enable_b;
            ADDR_FLAGS_A:     next_rdata = interrupt_flags_a;
            ADDR_PIN_SELECT:  next_rdata = peripheral_pin_select;
            ADDR_PRIORITY_B:  next_rdata = priority_level_b;
            ADDR_PRIORITY_A:  next_rdata = priority_level_a;
            ADDR_EDGE_SELECT: next_rdata = ext_irq_edge_select;
            default:          next_rdata = 8'h00;
        endcase
    end

    // read data registered, holds until the next read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end

endmodule

// ### tb/ifpeu_chk.sv
`timescale 1ns/1ps
module ifpeu_chk
    import ifpeu_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // events and core state
    input wire logic [4:0] periph_event,
    input wire logic       svc_low,
    input wire logic       svc_high,
    // pins and results
    input wire logic       port_d_bit0,
    input wire logic       port_d_bit6,
    input wire logic       irq_req,
    input wire logic       irq_high,
    input wire logic       ext_edge_line0,
    input wire logic       ext_edge_line1,
    input wire logic       idle_wake
);
    logic       en_iic;
    logic [2:0] route_q;
    logic [3:0] cfg_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // shadow only the fields the properties lean on
    always_ff @(posedge clk) begin
        if (!nrst) begin
            en_iic  <= 1'b0;
            route_q <= RST_PIN_SELECT[2:0];
            cfg_q   <= RST_EDGE_SELECT[3:0];
        end else if (sfr_wr) begin
            if (sfr_addr == ADDR_ENABLE_A) en_iic <= sfr_wdata[3];
            if (sfr_addr == ADDR_PIN_SELECT) route_q <= sfr_wdata[2:0];
            if (sfr_addr == ADDR_EDGE_SELECT) cfg_q <= sfr_wdata[3:0];
        end
    end

    // no service and no write, so nothing masks the request
    sequence s_calm;
        !svc_high && !svc_low && !sfr_wr;
    endsequence
    sequence s_iic_evt;
        periph_event[0] && en_iic ##0 s_calm ##1 s_calm;
    endsequence

    property p_flag_rsvd;
        sfr_rd && sfr_addr == ADDR_FLAGS_A |=> sfr_rdata[1:0] == 2'h0;
    endproperty
    property p_prio_rsvd;
        sfr_rd && sfr_addr == ADDR_PRIORITY_B |=> sfr_rdata[7:3] == 5'h00;
    endproperty
    property p_en_rsvd;
        sfr_rd && sfr_addr == ADDR_ENABLE_B |=> sfr_rdata[7:3] == 5'h00;
    endproperty
    property p_evt_req;
        s_iic_evt |=> irq_req;
    endproperty
    property p_high_block;
        svc_high [*2] |-> !irq_req;
    endproperty
    property p_high_req;
        irq_high |-> irq_req && !$past(svc_high);
    endproperty
    // a pin holds at least three cycles, so two back shows the new level
    property p_dir0;
        ext_edge_line0 && cfg_q[1] != cfg_q[0]
            |-> $past(port_d_bit0, 2) == cfg_q[1];
    endproperty
    property p_dir1;
        ext_edge_line1 && cfg_q[3] != cfg_q[2]
            |-> $past(port_d_bit6, 2) == cfg_q[3];
    endproperty
    property p_off0;
        !route_q[0] [*6] |-> !ext_edge_line0;
    endproperty
    property p_off1;
        !route_q[1] [*6] |-> !ext_edge_line1;
    endproperty
    property p_wake;
        idle_wake && route_q == 3'h1 && cfg_q[1:0] == EDGE_RISING
            |-> $past(port_d_bit0, 2) || $past(port_d_bit0, 3)
             || $past(port_d_bit0, 4) || $past(port_d_bit0, 5);
    endproperty

    a_flag_rsvd: assert property (p_flag_rsvd)
        else $error("flag reserved bits read nonzero");
    a_prio_rsvd: assert property (p_prio_rsvd)
        else $error("priority reserved bits read nonzero");
    a_en_rsvd: assert property (p_en_rsvd)
        else $error("enable reserved bits read nonzero");
    a_evt_req: assert property (p_evt_req)
        else $error("enabled event gave no request");
    a_high_block: assert property (p_high_block)
        else $error("request during high service");
    a_high_req: assert property (p_high_req)
        else $error("high marker without request");
    a_dir0: assert property (p_dir0)
        else $error("line zero pulsed on wrong edge");
    a_dir1: assert property (p_dir1)
        else $error("line one pulsed on wrong edge");
    a_off0: assert property (p_off0)
        else $error("unrouted line zero pulsed");
    a_off1: assert property (p_off1)
        else $error("unrouted line one pulsed");
    a_wake: assert property (p_wake)
        else $error("rising line woke without high level");
endmodule

bind ifpeu_top ifpeu_chk ifpeu_chk_inst (.clk, .nrst, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .periph_event, .svc_low, .svc_high,
    .port_d_bit0, .port_d_bit6, .irq_req, .irq_high, .ext_edge_line0,
    .ext_edge_line1, .idle_wake);

// ### tb/ifpeu_pin_model.sv
`timescale 1ns/1ps
module ifpeu_pin_model (
    // clock and pacing
    input  wire logic       clk,
    input  wire logic       slow,
    // requested levels and drive enables
    input  wire logic [2:0] want_lvl,
    input  wire logic [2:0] want_drv,
    // pads: 0 is bit 0, 1 is bit 6, 2 is bit 7
    output logic      [2:0] pad
);
    logic [2:0] stage_a = 3'h7;
    logic [2:0] stage_b = 3'h7;
    // released pads float up on the pull-ups
    always_ff @(posedge clk) begin
        stage_a <= want_lvl | ~want_drv;
        stage_b <= stage_a;
    end
    // slow source lands later; only switch pacing while pads are quiet
    assign pad = slow ? stage_b : stage_a;
endmodule

// ### tb/interrupt_flag_priority_edge_unit_tb_top.sv
`timescale 1ns/1ps
module interrupt_flag_priority_edge_unit_tb_top
    import ifpeu_pkg::*;
;
    localparam logic [7:0] ADR [8] = '{ADDR_ENABLE_A, ADDR_ENABLE_B,
        ADDR_FLAGS_A, ADDR_PIN_SELECT, ADDR_PRIORITY_B, ADDR_PRIORITY_A,
        ADDR_EDGE_SELECT, 8'hf0};
    localparam logic [7:0] RST [8] = '{RST_ENABLE_A, RST_ENABLE_B,
        RST_FLAGS_A, RST_PIN_SELECT, RST_PRIORITY_B, RST_PRIORITY_A,
        RST_EDGE_SELECT, 8'h00};
    localparam logic [7:0] MSK [8] = '{MASK_ENABLE_A, MASK_ENABLE_B,
        MASK_FLAGS_A, MASK_PIN_SELECT, MASK_PRIORITY_B, MASK_PRIORITY_A,
        MASK_EDGE_SELECT, 8'h00};
    logic       clk;
    logic       nrst;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] pev;
    logic [2:0] rflag;
    logic       svc_low;
    logic       svc_high;
    logic       idle;
    logic [2:0] lvl;
    logic       slow;
    logic [2:0] pad;
    logic       irq_req;
    logic       irq_high;
    ifpeu_src_t irq_src;
    logic [1:0] edge_out;
    logic       wake;
    logic [7:0] d;
    logic [7:0] v;
    logic [8:0] hi;
    logic [8:0] pend;
    int         err_total;
    int         compares;
    int         pulses [2];

    ifpeu_top ifpeu_top_inst (.clk(clk), .nrst(nrst), .sfr_addr(addr),
        .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
        .periph_event(pev), .remote_flag(rflag), .svc_low(svc_low),
        .svc_high(svc_high), .idle_mode(idle), .port_d_bit0(pad[0]),
        .port_d_bit6(pad[1]), .port_d_bit7(pad[2]), .irq_req(irq_req),
        .irq_high(irq_high), .irq_src(irq_src),
        .ext_edge_line0(edge_out[0]), .ext_edge_line1(edge_out[1]),
        .idle_wake(wake));
    ifpeu_pin_model ifpeu_pin_model_inst (.clk(clk), .slow(slow),
        .want_lvl(lvl), .want_drv(3'h7), .pad(pad));

    // ****
    // clock, pulse tally and watchdog
    // ****
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (edge_out[0]) pulses[0]++;
        if (edge_out[1]) pulses[1]++;
    end
    // whole plan needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end

    // ****
    // bus tasks and compares
    // ****
    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %b seen %b", n, e, g);
            err_total++;
        end
    endtask
    task automatic wait_clk(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        wait_clk(3);
        nrst <= 1'b1;
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] x);
        @(posedge clk);
        addr  <= a;
        wdata <= x;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    // lowest index wins inside a level, high level first
    function automatic logic [4:0] pick(logic [8:0] p, logic [8:0] h);
        for (int i = 0; i < 9; i++)
            if (p[i] && h[i]) return {1'b1, 4'(i)};
        for (int i = 0; i < 9; i++)
            if (p[i]) return {1'b0, 4'(i)};
        return 5'h00;
    endfunction
    task automatic end_sim();
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        {nrst, addr, wr, rd, wdata, pev, rflag} = '0;
        {svc_low, svc_high, idle, slow} = '0;
        lvl = 3'h7;
        void'($urandom(32'h5174));
        do_reset();
        // reset values, unmapped place reads zero
        for (int i = 0; i < 8; i++) begin
            rd_reg(ADR[i]);
            chk_byte("reset_value", RST[i], d);
        end
        // random write and read back, reserved bits written only at the unmapped place
        for (int i = 0; i < 24; i++) begin
            v = (i % 8 == 7) ? 8'($urandom) : 8'($urandom) & MSK[i % 8];
            wr_reg(ADR[i % 8], v);
            rd_reg(ADR[i % 8]);
            chk_byte("readback", v & MSK[i % 8], d);
        end
        do_reset();
        wr_reg(ADDR_ENABLE_A, MASK_ENABLE_A);
        wr_reg(ADDR_ENABLE_B, MASK_ENABLE_B);
        // arbitration over random pending sets and levels
        for (int r = 0; r < 10; r++) begin
            hi   = 9'($urandom);
            pend = 9'($urandom);
            if (r < 2) begin
                pend = 9'h1ff;
                hi   = {9{r[0]}};
            end
            rflag <= pend[2:0];
            wr_reg(ADDR_PRIORITY_A, {hi[8:3], 2'h0});
            wr_reg(ADDR_PRIORITY_B, {5'h00, hi[2:0]});
            wr_reg(ADDR_FLAGS_A, {pend[8:3], 2'h0});
            wait_clk(3);
            chk_bit("irq_req", |pend, irq_req);
            if (|pend)
                chk_byte("pick", {3'h0, pick(pend, hi)},
                         {3'h0, irq_high, irq_src});
        end
        rflag <= 3'h0;
        wr_reg(ADDR_FLAGS_A, 8'h00);
        // each peripheral event sets its own flag
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            pev <= 5'(1 << k);
            @(posedge clk);
            pev <= 5'h00;
            wait_clk(3);
            chk_byte("event_src", 8'(k + 4), {4'h0, irq_src});
            rd_reg(ADDR_FLAGS_A);
            chk_byte("event_flag", 8'(8 << k), d);
            wr_reg(ADDR_FLAGS_A, 8'h00);
        end
        // low service holds low requests, high one preempts
        wr_reg(ADDR_PRIORITY_A, 8'h00);
        wr_reg(ADDR_PRIORITY_B, 8'h00);
        wr_reg(ADDR_FLAGS_A, 8'h10);
        svc_low <= 1'b1;
        wait_clk(3);
        chk_bit("low_held", 1'b0, irq_req);
        wr_reg(ADDR_PRIORITY_A, 8'h10);
        wait_clk(3);
        chk_bit("preempt", 1'b1, irq_req & irq_high);
        svc_high <= 1'b1;
        wait_clk(3);
        chk_bit("high_held", 1'b0, irq_req);
        svc_high <= 1'b0;
        svc_low  <= 1'b0;
        // every edge code on every routed line, both pin directions
        for (int l = 0; l < 3; l++) begin
            for (int c = 0; c < 4; c++) begin
                wr_reg(ADDR_PIN_SELECT, 8'(1 << l));
                wr_reg(ADDR_EDGE_SELECT, 8'(c << (2 * l)));
                for (int e = 0; e < 2; e++) begin
                    v = 8'(pulses[l % 2]);
                    lvl[l] <= e[0];
                    wait_clk(10);
                    if (l == 2) begin
                        rd_reg(ADDR_FLAGS_A);
                        wr_reg(ADDR_FLAGS_A, 8'h00);
                    end
                    d[0] = (l == 2) ? d[2] : (v != 8'(pulses[l]));
                    v[0] = (c == 1) ? (e == 0) : (c == 2) ? (e == 1) : 1'b1;
                    chk_bit("edge_seen", v[0], d[0]);
                end
            end
        end
        // unrouted pins never count, slow source this time
        do_reset();
        slow <= 1'b1;
        v = 8'(pulses[0] + pulses[1]);
        lvl <= 3'h0;
        wait_clk(10);
        lvl <= 3'h7;
        wait_clk(10);
        chk_byte("unrouted", v, 8'(pulses[0] + pulses[1]));
        rd_reg(ADDR_FLAGS_A);
        chk_byte("unrouted_flag", 8'h00, d);
        // idle wake level follows the edge code
        do_reset();
        slow <= 1'b0;
        idle <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr_reg(ADDR_EDGE_SELECT, (s < 2) ? 8'h02 : 8'(s - 2));
            wr_reg(ADDR_PIN_SELECT, 8'h01);
            lvl[0] <= (s == 1 || s == 2);
            wait_clk(8);
            chk_bit("wake", s[0], wake);
        end
        end_sim();
    end
endmodule
